// file: hdl/ddrp_pkg.sv
/*
  Shared constants of the DDR pin link: widths, command pin codes,
  power states and link clock timing.
  Assumes one system clock at 125 MHz on both ends of the link.
*/
// Function
// [RQ1] Sample address and control on rising clock crossing
// [RQ2] Read data timed to both clock crossings
// [RQ3] Clock-enable high runs, low stops the device
// [RQ4] Idle banks: precharge power-down or self refresh
// [RQ5] Enable synchronous for entry, asynchronous for exit; power-down exit here still waits for a rising crossing
// [RQ6] Controller holds clock-enable high during accesses
// [RQ7] Power-down and self refresh disable input buffers
// [RQ8] Chip select high masks the command
// [RQ9] Command from strobes and select, same edge
// [RQ10] Bank inputs pick one of four banks
// [RQ11] Address carries row, or column plus auto-precharge
// [RQ12] Address bit ten picks one or all banks
// [RQ13] Mode load: bank inputs choose mode register
// [RQ14] High write mask discards that data beat
// [RQ15] Low mask low byte, high mask high byte
// [RQ16] Strobe edge-aligned on read, centred on write
// [RQ17] Low strobe times low byte, high strobe high
// [RQ18] No activate before auto-precharge read completes
// [RQ19] Data and strobes released unless returning read data
package ddrp_pkg;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 13;
  localparam int LANES = 2;
  localparam int PRE_ALL_BIT = 10;
  localparam int MEM_IDX_W = 5;
  // Link clock half period in system clocks (period 8 x 8 ns = 64 ns)
  localparam logic [2:0] CK_HALF = 3'h4;
  localparam logic [2:0] PH_RISE = 3'h0;
  localparam logic [2:0] PH_MID_HI = 3'h2;
  localparam logic [2:0] PH_FALL = 3'h4;
  localparam logic [2:0] PH_MID_LO = 3'h6;
  localparam logic [2:0] RD_TIMEOUT = 3'h4;
  // Command pin codes {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0000;
  typedef enum logic [3:0] {
    PWR_RUN = 4'b0001,
    PWR_PDN_PRE = 4'b0010,
    PWR_PDN_ACT = 4'b0100,
    PWR_SREF = 4'b1000
  } ddrp_pwr_e;
endpackage

// file: hdl/ddrp_link_if.sv
/*
  Pin bundle between the controller end and the DRAM end.
  Two-way data and strobe pins are resolved here from the enables.
*/
`timescale 1ns/1ps
interface ddrp_link_if;
  import ddrp_pkg::*;
  logic ck;
  logic clockComplement;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic bankSelLo;
  logic bankSelHi;
  logic [ADDR_W-1:0] addr;
  logic writeMaskLowByte;
  logic writeMaskHighByte;
  logic [DQ_W-1:0] dqCtlOut;
  logic [LANES-1:0] dqCtlOe;
  logic [DQ_W-1:0] dqDevOut;
  logic [LANES-1:0] dqDevOe;
  logic [LANES-1:0] strobeCtlOut;
  logic [LANES-1:0] strobeCtlOe;
  logic [LANES-1:0] strobeDevOut;
  logic [LANES-1:0] strobeDevOe;
  wire [DQ_W-1:0] dqIn;
  wire [LANES-1:0] strobeIn;

  // Wire level per byte lane from whichever end drives it; an undriven
  // lane reads low, as a pull-down would park it, so no edge is invented
  for (genvar g = 0; g < LANES; g++) begin : gLane
    assign dqIn[8*g +: 8] = dqDevOe[g] ? dqDevOut[8*g +: 8] :
                            dqCtlOe[g] ? dqCtlOut[8*g +: 8] : 8'h00;
    assign strobeIn[g] = strobeDevOe[g] ? strobeDevOut[g] :
                         strobeCtlOe[g] ? strobeCtlOut[g] : 1'b0;
  end

  modport ctl (
    output ck, clockComplement, cke, csN, rasN, casN, weN, bankSelLo, bankSelHi, addr,
    output writeMaskLowByte, writeMaskHighByte, dqCtlOut, dqCtlOe, strobeCtlOut, strobeCtlOe,
    input dqIn, strobeIn
  );
  modport dev (
    input ck, clockComplement, cke, csN, rasN, casN, weN, bankSelLo, bankSelHi, addr,
    input writeMaskLowByte, writeMaskHighByte, dqIn, strobeIn,
    output dqDevOut, dqDevOe, strobeDevOut, strobeDevOe
  );
endinterface

// file: hdl/ddrp_buf2.sv
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes producer and consumer on clk_sys.
*/
`timescale 1ns/1ps
module ddrp_buf2 import ddrp_pkg::*; #(
  parameter int WIDTH = 2 * DQ_W,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic inValid, // Word offered
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Word in
  output logic outValid, // Word available
  input wire logic outReady, // Consumer takes word
  output logic [WIDTH-1:0] outData // Oldest word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  // Honest full and empty from the occupancy count
  assign inReady = (count_r < (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = store[rdPtr_r];

  // Pointers and occupancy
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= PW'(wrPtr_r + 1'b1);
      if (pop) rdPtr_r <= PW'(rdPtr_r + 1'b1);
      count_r <= (PW+1)'(count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_sys) begin
    if (push) store[wrPtr_r] <= inData;
  end
endmodule

// file: hdl/ddrp_ctrl.sv
/*
  Controller end: makes the link clock by a divider, drives commands,
  write data with centred strobes, and captures read data.
  Assumes the DRAM end answers a read half a link clock after it.
*/
`timescale 1ns/1ps
module ddrp_ctrl import ddrp_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  ddrp_link_if.ctl link, // Pins toward the DRAM
  input wire logic cmdValid, // Command offered
  output logic cmdReady, // Command taken this cycle
  input wire logic cmdChipSel, // 1 selects the device
  input wire logic [2:0] cmdCode, // {rasN, casN, weN}
  input wire logic [1:0] cmdBank, // Bank number
  input wire logic [ADDR_W-1:0] cmdAddr, // Row, column or op code
  input wire logic [2*DQ_W-1:0] cmdWrData, // Beat1, beat0
  input wire logic [3:0] cmdWrMask, // Per byte per beat, 1 masks
  input wire logic ckeReq, // Requested clock-enable level
  output logic rdValid, // Read word available
  input wire logic rdReady, // Read word taken
  output logic [2*DQ_W-1:0] rdData, // Beat1, beat0
  output logic busy // Access in progress
);
  typedef enum logic [3:0] {
    C_IDLE = 4'b0001, C_CMD = 4'b0010, C_WDATA = 4'b0100, C_RWAIT = 4'b1000
  } ddrp_cst_e;
  ddrp_cst_e st_r;
  logic [2:0] ph_r;
  logic [3:0] cmdPins_r;
  logic [2*DQ_W-1:0] wrData_r;
  logic [3:0] wrMask_r;
  logic [2:0] waitCnt_r;
  logic [DQ_W-1:0] beat0_r;
  logic [1:0] strbS1_r, strbS2_r, strbD_r;
  logic [DQ_W-1:0] dqS1_r, dqS2_r;
  logic bufInValid, bufInReady;

  wire atFall = (ph_r == PH_FALL);
  wire take = (st_r == C_IDLE) && atFall && cmdValid && bufInReady;
  // Only accesses force clock-enable high, so self refresh can still be entered
  wire takeAccess = (cmdCode == CMD_WRITE[2:0]) || (cmdCode == CMD_READ[2:0]);
  wire strbRise = strbS2_r[0] & ~strbD_r[0];
  wire strbFall = ~strbS2_r[0] & strbD_r[0];
  assign cmdReady = take;
  assign busy = (st_r != C_IDLE);
  assign bufInValid = (st_r == C_RWAIT) && strbFall;

  // Free-running divider makes the link clock pair
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_r <= '0;
      link.ck <= 1'b1;
      link.clockComplement <= 1'b0;
    end else begin
      ph_r <= 3'(ph_r + 1'b1);
      link.ck <= (3'(ph_r + 1'b1) < CK_HALF);
      link.clockComplement <= !(3'(ph_r + 1'b1) < CK_HALF);
    end
  end

  // Read pins pass two flops before use
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strbS1_r <= '0;
      strbS2_r <= '0;
      strbD_r <= '0;
      dqS1_r <= '0;
      dqS2_r <= '0;
    end else begin
      strbS1_r <= link.strobeIn;
      strbS2_r <= strbS1_r;
      strbD_r <= strbS2_r;
      dqS1_r <= link.dqIn;
      dqS2_r <= dqS1_r;
    end
  end

  // Sequencer: command pins change at the link clock fall, stable at the rise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= C_IDLE;
      cmdPins_r <= CMD_NOP;
      link.cke <= 1'b0;
      {link.csN, link.rasN, link.casN, link.weN} <= CMD_NOP;
      {link.bankSelHi, link.bankSelLo} <= 2'h0;
      link.addr <= '0;
      link.dqCtlOut <= '0;
      link.dqCtlOe <= '0;
      link.strobeCtlOut <= '0;
      link.strobeCtlOe <= '0;
      {link.writeMaskHighByte, link.writeMaskLowByte} <= 2'h0;
      wrData_r <= '0;
      wrMask_r <= '0;
      waitCnt_r <= '0;
      beat0_r <= '0;
    end else begin
      // Clock-enable follows the request only between accesses
      if (atFall && (st_r == C_IDLE) && !take) link.cke <= ckeReq; // RQ6
      if (take) link.cke <= takeAccess | ckeReq; // RQ6
      case (st_r)
        C_IDLE: begin
          if (take) begin
            // Command is the select and three strobes on one edge
            {link.csN, link.rasN, link.casN, link.weN} <= {!cmdChipSel, cmdCode}; // RQ9
            cmdPins_r <= {!cmdChipSel, cmdCode};
            {link.bankSelHi, link.bankSelLo} <= cmdBank; // RQ10 RQ13
            link.addr <= cmdAddr; // RQ11 RQ12 RQ13
            wrData_r <= cmdWrData;
            wrMask_r <= cmdWrMask;
            st_r <= C_CMD;
          end
        end
        C_CMD: begin
          if (atFall) begin
            {link.csN, link.rasN, link.casN, link.weN} <= CMD_NOP;
            waitCnt_r <= '0;
            if (cmdPins_r == CMD_WRITE) begin
              link.dqCtlOut <= wrData_r[DQ_W-1:0];
              {link.writeMaskHighByte, link.writeMaskLowByte} <= wrMask_r[1:0];
              link.dqCtlOe <= '1;
              link.strobeCtlOut <= '0;
              link.strobeCtlOe <= '1;
              st_r <= C_WDATA;
            end else if (cmdPins_r == CMD_READ) begin
              st_r <= C_RWAIT;
            end else begin
              st_r <= C_IDLE;
            end
          end
        end
        C_WDATA: begin
          // Strobe edges fall midway in each data beat
          if (ph_r == PH_MID_LO) link.strobeCtlOut <= '1; // RQ16 RQ17
          if (ph_r == PH_RISE) begin
            link.dqCtlOut <= wrData_r[2*DQ_W-1:DQ_W];
            {link.writeMaskHighByte, link.writeMaskLowByte} <= wrMask_r[3:2]; // RQ14 RQ15
          end
          if (ph_r == PH_MID_HI) link.strobeCtlOut <= '0; // RQ16
          if (atFall) begin
            link.dqCtlOe <= '0;
            link.strobeCtlOe <= '0;
            st_r <= C_IDLE;
          end
        end
        C_RWAIT: begin
          if (strbRise) beat0_r <= dqS2_r;
          if (atFall) waitCnt_r <= 3'(waitCnt_r + 1'b1);
          // Give up if the read answer never arrives
          if (strbFall || (waitCnt_r == RD_TIMEOUT)) st_r <= C_IDLE;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end

  // Read words queue here so a stalled consumer loses none
  ddrp_buf2 #(.WIDTH(2 * DQ_W), .DEPTH(2)) uBuf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData({dqS2_r, beat0_r}),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );
endmodule

// file: hdl/ddrp_dram.sv
/*
  DRAM end: samples the link clock pair, decodes commands, tracks open
  rows, power state and mode registers, and moves masked burst-of-two data.
  Assumes the link clock is slow enough to be sampled by clk_sys.
*/
`timescale 1ns/1ps
module ddrp_dram import ddrp_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  ddrp_link_if.dev link, // Pins from the controller
  output ddrp_pwr_e pwrState, // Current power state
  output logic [3:0] bankOpen, // Row open per bank
  output logic [ADDR_W-1:0] modeBase, // Base mode register
  output logic [ADDR_W-1:0] modeExt // Extended mode register
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ckS1_r, ckS2_r, ckD_r;
  logic ckeS1_r, ckeS2_r;
  logic [ADDR_W+6:0] cmdS1_r, cmdS2_r;
  logic [DQ_W+1:0] dqS1_r, dqS2_r;
  logic [1:0] strbS1_r, strbS2_r, strbD_r;

  // Every pin passes two flops before any logic reads it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ckS1_r <= '0;
      ckS2_r <= '0;
      ckD_r <= '0;
      ckeS1_r <= 1'b0;
      ckeS2_r <= 1'b0;
      cmdS1_r <= '1;
      cmdS2_r <= '1;
      dqS1_r <= '0;
      dqS2_r <= '0;
      strbS1_r <= '0;
      strbS2_r <= '0;
      strbD_r <= '0;
    end else begin
      ckS1_r <= {link.ck, link.clockComplement};
      ckS2_r <= ckS1_r;
      ckD_r <= ckS2_r;
      ckeS1_r <= link.cke;
      ckeS2_r <= ckeS1_r;
      cmdS1_r <= {link.csN, link.rasN, link.casN, link.weN, link.bankSelHi, link.bankSelLo,
                  link.addr, 1'b0};
      cmdS2_r <= cmdS1_r;
      dqS1_r <= {link.writeMaskHighByte, link.writeMaskLowByte, link.dqIn};
      dqS2_r <= dqS1_r;
      strbS1_r <= link.strobeIn;
      strbS2_r <= strbS1_r;
      strbD_r <= strbS2_r;
    end
  end

  // ----------------------------------------------------------------
  // Clock crossings and command decode
  // ----------------------------------------------------------------
  wire ckeOn = ckeS2_r; // RQ3
  wire inSref = (pwrState == PWR_SREF);
  // Crossing where true clock rises as its complement falls
  wire ckRise = ckS2_r[1] & ~ckD_r[1] & ~ckS2_r[0] & ckD_r[0] & !inSref; // RQ1 RQ7
  wire ckFall = ~ckS2_r[1] & ckD_r[1] & ckS2_r[0] & ~ckD_r[0] & !inSref; // RQ2 RQ7
  wire running = (pwrState == PWR_RUN);
  wire [3:0] cmdPins = cmdS2_r[ADDR_W+6:ADDR_W+3];
  wire [1:0] bank = cmdS2_r[ADDR_W+2:ADDR_W+1];
  wire [ADDR_W-1:0] addrIn = cmdS2_r[ADDR_W:1];
  // Command buffers are live only while running and selected
  wire cmdTake = ckRise && running && ckeOn && !cmdPins[3]; // RQ3 RQ7 RQ8 RQ9
  wire isAct = cmdTake && (cmdPins == CMD_ACTIVATE);
  wire isRead = cmdTake && (cmdPins == CMD_READ);
  wire isWrite = cmdTake && (cmdPins == CMD_WRITE);
  wire isPre = cmdTake && (cmdPins == CMD_PRECHARGE);
  wire isMode = cmdTake && (cmdPins == CMD_MODE);
  wire isRefresh = ckRise && running && !cmdPins[3] && (cmdPins == CMD_REFRESH);
  wire autoPre = addrIn[PRE_ALL_BIT]; // RQ11
  wire [MEM_IDX_W-2:0] colIdx = {bank, addrIn[1:0]}; // RQ10 RQ11

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Entries wait for a sampled edge; self-refresh exit does not
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pwrState <= PWR_PDN_PRE;
    end else begin
      case (pwrState)
        PWR_RUN: begin
          if (ckRise && !ckeOn) begin // RQ5
            if (isRefresh || (!cmdPins[3] && cmdPins == CMD_REFRESH)) pwrState <= PWR_SREF; // RQ4
            else if (bankOpen != 4'h0) pwrState <= PWR_PDN_ACT; // RQ4
            else pwrState <= PWR_PDN_PRE; // RQ4
          end
        end
        PWR_PDN_PRE, PWR_PDN_ACT: begin
          if (ckRise && ckeOn) pwrState <= PWR_RUN; // RQ5
        end
        PWR_SREF: begin
          if (ckeOn) pwrState <= PWR_RUN; // RQ5
        end
        default: pwrState <= PWR_PDN_PRE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Banks and mode registers
  // ----------------------------------------------------------------
  // Row tracking per bank; auto-precharge closes the row as the read or write command is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bankOpen <= 4'h0;
      modeBase <= MODE_RESET;
      modeExt <= MODE_RESET;
    end else begin
      if (isAct) bankOpen[bank] <= 1'b1; // RQ10 RQ11
      if ((isRead || isWrite) && autoPre) bankOpen[bank] <= 1'b0; // RQ11 RQ18
      if (isPre && autoPre) bankOpen <= 4'h0; // RQ12
      if (isPre && !autoPre) bankOpen[bank] <= 1'b0; // RQ12
      if (isMode && bank == 2'h0) modeBase <= addrIn; // RQ13
      if (isMode && bank == 2'h1) modeExt <= addrIn; // RQ13
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic rdPend_r, rdBeat1_r, rdDrive_r;
  logic [MEM_IDX_W-2:0] rdIdx_r;
  logic [MEM_IDX_W-2:0] wrIdx_r;
  logic [DQ_W-1:0] rdWord0, rdWord1;

  // Data and strobe change on clock crossings, edge aligned
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdPend_r <= 1'b0;
      rdBeat1_r <= 1'b0;
      rdDrive_r <= 1'b0;
      rdIdx_r <= '0;
      wrIdx_r <= '0;
      link.dqDevOut <= '0;
      link.strobeDevOut <= '0;
    end else if (ckeOn) begin
      if (isRead) begin
        rdPend_r <= 1'b1;
        rdIdx_r <= colIdx;
      end
      if (isWrite) wrIdx_r <= colIdx;
      if (ckFall && rdPend_r) begin
        rdPend_r <= 1'b0;
        rdBeat1_r <= 1'b1;
        rdDrive_r <= 1'b1;
        link.dqDevOut <= rdWord0; // RQ2
        link.strobeDevOut <= '1; // RQ16
      end else if (ckRise && rdBeat1_r) begin
        rdBeat1_r <= 1'b0;
        link.dqDevOut <= rdWord1; // RQ2
        link.strobeDevOut <= '0; // RQ16
      end else if (ckFall && rdDrive_r && !rdBeat1_r) begin
        rdDrive_r <= 1'b0;
      end
    end
  end

  // Drivers drop at once when clock-enable falls
  assign link.dqDevOe = {LANES{rdDrive_r & ckeOn}}; // RQ5 RQ19
  assign link.strobeDevOe = {LANES{rdDrive_r & ckeOn}}; // RQ19

  // ----------------------------------------------------------------
  // Write path, one strobe and one memory per byte lane
  // ----------------------------------------------------------------
  logic [LANES-1:0] wrPend_r;
  logic [LANES-1:0] wrBeat_r;

  for (genvar g = 0; g < LANES; g++) begin : gLane
    logic [7:0] mem [2**MEM_IDX_W];
    wire sRise = strbS2_r[g] & ~strbD_r[g];
    wire sFall = ~strbS2_r[g] & strbD_r[g];
    wire masked = dqS2_r[DQ_W+g]; // RQ15
    wire [MEM_IDX_W-1:0] wAddr = {wrIdx_r, wrBeat_r[g]};
    assign rdWord0[8*g +: 8] = mem[{rdIdx_r, 1'b0}];
    assign rdWord1[8*g +: 8] = mem[{rdIdx_r, 1'b1}];

    // Each lane counts its own strobe edges
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        wrPend_r[g] <= 1'b0;
        wrBeat_r[g] <= 1'b0;
      end else begin
        if (isWrite) begin
          wrPend_r[g] <= 1'b1;
          wrBeat_r[g] <= 1'b0;
        end else if (wrPend_r[g] && sRise) begin
          wrBeat_r[g] <= 1'b1; // RQ16 RQ17
        end else if (wrPend_r[g] && sFall && wrBeat_r[g]) begin
          wrPend_r[g] <= 1'b0; // RQ17
        end
      end
    end

    // Beat stored on strobe edge unless its mask was high
    always_ff @(posedge clk_sys) begin
      if (wrPend_r[g] && (sRise || sFall) && !masked) begin // RQ14
        mem[wAddr] <= dqS2_r[8*g +: 8]; // RQ15 RQ16
      end
    end
  end
endmodule

// file: test/ddrp_link_chk.sv
/*
  Checker on the pin link between the controller end and the DRAM end.
  Assumes the bench places it beside the link interface, one clock domain.
*/
`timescale 1ns/1ps
module ddrp_link_chk import ddrp_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Reset, low
  input wire logic ck, // Link clock
  input wire logic clockComplement, // Its complement
  input wire logic cke, // Clock enable
  input wire logic csN, // Select, low
  input wire logic rasN, // Row strobe
  input wire logic casN, // Column strobe
  input wire logic weN, // Write strobe
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic [DQ_W-1:0] dqCtlOut, // Write data
  input wire logic [LANES-1:0] dqCtlOe, // Write drive
  input wire logic [LANES-1:0] strobeCtlOut, // Write strobe
  input wire logic [LANES-1:0] dqDevOe, // Read drive
  input wire logic [LANES-1:0] strobeDevOut, // Read strobe
  input wire logic [LANES-1:0] strobeDevOe // Read strobe drive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ------
  // Pin timing
  // ------
  // Command, address and clock-enable pins may only move while ck is low, so each rise sees settled levels
  wire [16:0] cmdPins = {csN, rasN, casN, weN, addr};
  property p_ckPair; clockComplement == !ck; endproperty
  a_ckPair: assert property (p_ckPair) else $error("clock pair not complementary");
  property p_ckPeriod; $rose(ck) |=> ck [*3] ##1 !ck [*4] ##1 ck; endproperty
  a_ckPeriod: assert property (p_ckPeriod) else $error("link clock period wrong");
  property p_cmdSettle; $changed(cmdPins) |-> !ck ##1 !ck ##1 !ck; endproperty
  a_cmdSettle: assert property (p_cmdSettle) else $error("command pins move near rise");
  property p_ckeSettle; $changed(cke) |-> !ck ##1 !ck; endproperty
  a_ckeSettle: assert property (p_ckeSettle) else $error("clock enable moves near rise");
  // ------
  // Data and strobe drive
  // ------
  property p_noFight; (dqDevOe & dqCtlOe) == 2'h0; endproperty
  a_noFight: assert property (p_noFight) else $error("both ends drive data");
  property p_ckeHeld; (dqDevOe != 2'h0 || dqCtlOe != 2'h0) |-> cke; endproperty
  a_ckeHeld: assert property (p_ckeHeld) else $error("clock enable low in transfer");
  property p_readStart; $rose(strobeDevOe[0]) |-> strobeDevOut[0] && !ck; endproperty
  a_readStart: assert property (p_readStart) else $error("read strobe start wrong");
  // A read holds strobe high half a link period, then low half, then releases
  property p_readShape;
    $rose(strobeDevOe[0]) |-> (strobeDevOe[0] && strobeDevOut[0]) [*4]
      ##1 (strobeDevOe[0] && !strobeDevOut[0]) [*4] ##1 !strobeDevOe[0];
  endproperty
  a_readShape: assert property (p_readShape) else $error("read strobe shape wrong");
  property p_lanes;
    strobeDevOe != 2'h0 |-> strobeDevOe == 2'h3 && dqDevOe == 2'h3
      && strobeDevOut[1] == strobeDevOut[0];
  endproperty
  a_lanes: assert property (p_lanes) else $error("read lanes differ");
  // Write data must sit still a cycle either side of each strobe edge
  property p_writeCentre;
    dqCtlOe[0] && $past(dqCtlOe[0]) && $changed(strobeCtlOut[0])
      |-> $stable(dqCtlOut) ##1 $stable(dqCtlOut);
  endproperty
  a_writeCentre: assert property (p_writeCentre) else $error("write strobe not centred");
endmodule

// file: test/ddrp_tb.sv
/*
  Bench joining the controller end to the DRAM end over the pin link.
  Assumes package, interface, both ends and the checker compile first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb import ddrp_pkg::*; ;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdChipSel = 1'b1;
  logic [2:0] cmdCode = 3'h7;
  logic [1:0] cmdBank = 2'h0;
  logic [ADDR_W-1:0] cmdAddr = 13'h0000;
  logic [31:0] cmdWrData = 32'h0;
  logic [3:0] cmdWrMask = 4'h0;
  logic ckeReq = 1'b0;
  logic rdReady = 1'b0;
  logic cmdReady, rdValid, busy;
  logic [31:0] rdData;
  ddrp_pwr_e pwrState;
  logic [3:0] bankOpen;
  logic [ADDR_W-1:0] modeBase, modeExt;
  int errors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  ddrp_link_if link();
  wire [18:0] pinsSeen = {link.csN, link.rasN, link.casN, link.weN, link.bankSelHi,
    link.bankSelLo, link.addr};
  ddrp_ctrl u_ddrp_ctrl (.clk_sys, .resetn, .link, .cmdValid, .cmdReady, .cmdChipSel,
    .cmdCode, .cmdBank, .cmdAddr, .cmdWrData, .cmdWrMask, .ckeReq, .rdValid, .rdReady,
    .rdData, .busy);
  ddrp_dram u_ddrp_dram (.clk_sys, .resetn, .link, .pwrState, .bankOpen, .modeBase,
    .modeExt);
  ddrp_link_chk u_ddrp_link_chk (.clk_sys, .resetn, .ck(link.ck),
    .clockComplement(link.clockComplement), .cke(link.cke), .csN(link.csN),
    .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .addr(link.addr),
    .dqCtlOut(link.dqCtlOut), .dqCtlOe(link.dqCtlOe), .strobeCtlOut(link.strobeCtlOut),
    .dqDevOe(link.dqDevOe), .strobeDevOut(link.strobeDevOut),
    .strobeDevOe(link.strobeDevOe));
  // Clock and hang guard; the whole run needs about a thousand cycles at most
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------
  // Shared drivers
  // ------
  // Offer one command, hold it until taken, wait until not busy, then one link period more
  task automatic cmd(input logic cs, input logic [2:0] code, input logic [1:0] bank,
      input logic [ADDR_W-1:0] a, input logic [31:0] wd = 32'h0,
      input logic [3:0] wm = 4'h0, input logic ke = 1'b1);
    int n;
    @(posedge clk_sys) #1;
    {cmdValid, cmdChipSel, cmdCode, cmdBank, cmdAddr} = {1'b1, cs, code, bank, a};
    {cmdWrData, cmdWrMask, ckeReq} = {wd, wm, ke};
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cmdReady !== 1'b1 && n < 40);
    @(posedge clk_sys) #1;
    cmdValid = 1'b0;
    `CHK("cmdPins", {~cs, code, bank, a}, pinsSeen)
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk_sys) #1;
      n++;
    end
    repeat (8) @(posedge clk_sys) #1;
  endtask
  task automatic get(input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clk_sys) #1;
    while (rdValid !== 1'b1 && n < 64) begin
      @(posedge clk_sys) #1;
      n++;
    end
    `CHK("rdData", ex, rdData)
    rdReady = 1'b1;
    @(posedge clk_sys) #1;
    rdReady = 1'b0;
  endtask
  task automatic waitPwr(input ddrp_pwr_e ex);
    int n;
    n = 0;
    while (pwrState !== ex && n < 64) begin
      @(posedge clk_sys) #1;
      n++;
    end
    `CHK("pwrState", ex, pwrState)
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_power_up();
    `CHK("bankOpen", 4'h0, bankOpen)
    waitPwr(PWR_PDN_PRE);
    ckeReq = 1'b1;
    waitPwr(PWR_RUN);
  endtask
  task automatic t_mode();
    cmd(1'b1, CMD_MODE[2:0], 2'h0, 13'h0123);
    cmd(1'b1, CMD_MODE[2:0], 2'h1, 13'h1456);
    `CHK("modeBase", 13'h0123, modeBase)
    `CHK("modeExt", 13'h1456, modeExt)
  endtask
  // Masked rewrite keeps old bytes; two reads fill the buffer before draining
  task automatic t_write_read();
    cmd(1'b1, CMD_ACTIVATE[2:0], 2'h2, 13'h0ABC);
    `CHK("bankOpen", 4'h4, bankOpen)
    cmd(1'b1, CMD_WRITE[2:0], 2'h2, 13'h0004, 32'h44332211);
    cmd(1'b1, CMD_WRITE[2:0], 2'h2, 13'h0005, 32'h87654321);
    cmd(1'b1, CMD_WRITE[2:0], 2'h2, 13'h0004, 32'hDDCCBBAA, 4'h9);
    cmd(1'b1, CMD_READ[2:0], 2'h2, 13'h0004);
    cmd(1'b1, CMD_READ[2:0], 2'h2, 13'h0405);
    `CHK("bankOpen", 4'h0, bankOpen)
    get(32'h44CCBB11);
    get(32'h87654321);
  endtask
  task automatic t_precharge();
    cmd(1'b1, CMD_ACTIVATE[2:0], 2'h2, 13'h0ABC);
    cmd(1'b1, CMD_ACTIVATE[2:0], 2'h0, 13'h1FFF);
    `CHK("bankOpen", 4'h5, bankOpen)
    cmd(1'b1, CMD_PRECHARGE[2:0], 2'h0, 13'h0000);
    `CHK("bankOpen", 4'h4, bankOpen)
    cmd(1'b0, CMD_ACTIVATE[2:0], 2'h3, 13'h0000);
    `CHK("bankOpen", 4'h4, bankOpen)
    cmd(1'b1, CMD_PRECHARGE[2:0], 2'h1, 13'h0400);
    `CHK("bankOpen", 4'h0, bankOpen)
  endtask
  task automatic t_power();
    cmd(1'b1, CMD_ACTIVATE[2:0], 2'h1, 13'h0011);
    ckeReq = 1'b0;
    waitPwr(PWR_PDN_ACT);
    cmd(1'b1, CMD_PRECHARGE[2:0], 2'h0, 13'h0400, 32'h0, 4'h0, 1'b0);
    `CHK("bankOpen", 4'h2, bankOpen)
    ckeReq = 1'b1;
    waitPwr(PWR_RUN);
    cmd(1'b1, CMD_PRECHARGE[2:0], 2'h0, 13'h0400);
    ckeReq = 1'b0;
    waitPwr(PWR_PDN_PRE);
    ckeReq = 1'b1;
    waitPwr(PWR_RUN);
    cmd(1'b1, CMD_REFRESH[2:0], 2'h0, 13'h0000, 32'h0, 4'h0, 1'b0);
    waitPwr(PWR_SREF);
    ckeReq = 1'b1;
    waitPwr(PWR_RUN);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_power_up();
    t_mode();
    t_write_read();
    t_precharge();
    t_power();
    end_of_test();
  end
endmodule
